// File: rtl/lrot_pkg.sv
/*
 * Shared constants and types for the logical and rotate datapath:
 * operation and operand-form codes, operand location kinds, the per-form
 * instruction length and state table, and the location penalties.
 * Assumes one core clock where one instruction state is one clock cycle.
 */
`default_nettype none

package lrot_pkg;

    localparam int BYTE_W = 4;
    localparam int STATE_W = 6;
    localparam int WAIT_W = 3;
    localparam int DATA_W = 16;

    typedef enum logic [3:0] {
        bitwise_and_op,
        bitwise_or_op,
        bitwise_xor_op,
        zero_working_byte,
        invert_working_byte,
        rotate_left_plain,
        rotate_left_with_carry,
        rotate_right_plain,
        rotate_right_with_carry
    } alu_op_t;

    // Destination first, then source, as in the instruction encodings
    typedef enum logic [4:0] {
        form_acc_imm,
        form_acc_bank,
        form_acc_short,
        form_acc_ptr,
        form_short_acc,
        form_short_imm,
        form_reg_reg,
        form_wreg_wreg,
        form_reg_imm,
        form_wreg_imm,
        form_reg_short,
        form_wreg_short,
        form_reg_long,
        form_wreg_long,
        form_reg_ind_word,
        form_reg_ind_dword,
        form_acc_only
    } form_t;

    localparam int FORM_COUNT = 17;

    typedef enum logic [1:0] {
        loc_internal,
        loc_port,
        loc_sfr,
        loc_external
    } loc_t;

    // Table entry layout: legacy bytes, legacy states, native bytes, states
    localparam int LEG_BYTES_LSB = 12;
    localparam int LEG_STATES_LSB = 8;
    localparam int NAT_BYTES_LSB = 4;
    localparam int NAT_STATES_LSB = 0;

    localparam logic [15:0] FORM_TIMING [FORM_COUNT] = '{
        16'h2121,
        16'h1122,
        16'h2121,
        16'h1223,
        16'h2222,
        16'h3333,
        16'h3221,
        16'h3322,
        16'h4332,
        16'h5443,
        16'h4332,
        16'h4433,
        16'h5342,
        16'h5443,
        16'h4332,
        16'h4433,
        16'h1111
    };

    localparam logic [STATE_W-1:0] PORT_READ_ADD = 6'h01;
    localparam logic [STATE_W-1:0] SFR_READ_ADD = 6'h02;
    localparam logic [STATE_W-1:0] PORT_RMW_ADD = 6'h02;
    localparam logic [STATE_W-1:0] SFR_RMW_ADD = 6'h03;
    localparam logic [STATE_W-1:0] EXT_FIXED_ADD = 6'h02;

    localparam logic [7:0] WORKING_BYTE_RST = 8'h00;

endpackage

`default_nettype wire

// File: rtl/timing_if.sv
/*
 * Carrier between the datapath and its timing lookup: the operand form,
 * opcode mode, location and wait states go out, length and states return.
 * Assumes both ends sit in the same clock domain; the lookup is pure logic.
 */
`timescale 1ns/1ns
`default_nettype none

interface timing_if;
    import lrot_pkg::*;

    form_t form;
    logic native;
    loc_t loc;
    logic [WAIT_W-1:0] waits;
    logic [BYTE_W-1:0] bytes;
    logic [STATE_W-1:0] states;

    modport requester (output form, native, loc, waits, input bytes, states);
    modport lookup (input form, native, loc, waits, output bytes, states);
endinterface

`default_nettype wire

// File: rtl/instr_timing.sv
/*
 * Instruction length and state count for a logical or rotate instruction,
 * including port, peripheral register and external memory penalties.
 * Assumes the caller presents a stable form, mode, location and wait count.
 */
`timescale 1ns/1ns
`default_nettype none

module instr_timing
    import lrot_pkg::*;
(
    timing_if.lookup tim
);

    logic [15:0] entry_w;
    logic [BYTE_W-1:0] base_states_w;
    logic short_read_w;
    logic short_rmw_w;
    logic ext_byte_w;
    logic ext_word_w;
    logic [STATE_W-1:0] short_add_w;
    logic [STATE_W-1:0] ext_once_w;
    logic [STATE_W-1:0] ext_add_w;

    assign entry_w = FORM_TIMING[tim.form];
    assign tim.bytes = tim.native ? entry_w[NAT_BYTES_LSB +: BYTE_W]
                                  : entry_w[LEG_BYTES_LSB +: BYTE_W];
    assign base_states_w = tim.native ? entry_w[NAT_STATES_LSB +: BYTE_W]
                                      : entry_w[LEG_STATES_LSB +: BYTE_W];

    // Only the byte-wide short direct forms, not form_wreg_short, can reach ports or peripheral registers
    assign short_read_w = (tim.form == form_acc_short)
                       || (tim.form == form_reg_short);
    assign short_rmw_w = (tim.form == form_short_acc)
                      || (tim.form == form_short_imm);
    assign ext_byte_w = (tim.form == form_reg_long)
                     || (tim.form == form_reg_ind_word)
                     || (tim.form == form_reg_ind_dword);
    assign ext_word_w = (tim.form == form_wreg_long);

    assign short_add_w =
        (short_read_w && tim.loc == loc_port) ? PORT_READ_ADD :
        (short_read_w && tim.loc == loc_sfr) ? SFR_READ_ADD :
        (short_rmw_w && tim.loc == loc_port) ? PORT_RMW_ADD :
        (short_rmw_w && tim.loc == loc_sfr) ? SFR_RMW_ADD : 6'h00;

    assign ext_once_w = {3'h0, tim.waits} + EXT_FIXED_ADD;
    // Word operand costs two byte accesses on the external bus
    assign ext_add_w = (tim.loc != loc_external) ? 6'h00 :
                       ext_byte_w ? ext_once_w :
                       ext_word_w ? {ext_once_w[4:0], 1'b0} : 6'h00;

    assign tim.states = {2'h0, base_states_w} + short_add_w + ext_add_w;

endmodule

`default_nettype wire

// File: rtl/logic_rotate_alu.sv
/*
 * Execution datapath for logical and rotate instructions. Holds the
 * working byte and carry, status flags, and counts out each instruction's
 * states before committing its result.
 * Assumes the sequencer drives requests on the core clock, supplies the
 * destination and source operand values, and stores dest_wr_o results.
 */
`timescale 1ns/1ns
`default_nettype none

module logic_rotate_alu
    import lrot_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire alu_op_t op_i,
    input wire form_t form_i,
    input wire logic native_mode_i,
    input wire loc_t loc_i,
    input wire logic [WAIT_W-1:0] wait_states_i,
    input wire logic [DATA_W-1:0] dest_data_i,
    input wire logic [DATA_W-1:0] src_data_i,
    output logic busy_o,
    output logic done_o,
    output logic dest_wr_o,
    output logic [DATA_W-1:0] result_o,
    output logic [7:0] working_byte_o,
    output logic carry_flag_o,
    output logic zero_flag_o,
    output logic neg_flag_o,
    output logic [BYTE_W-1:0] instr_bytes_o,
    output logic [STATE_W-1:0] instr_states_o
);

    timing_if tim ();

    alu_op_t op_r;
    form_t form_r;
    logic [DATA_W-1:0] dst_r;
    logic [DATA_W-1:0] src_r;
    logic [STATE_W-1:0] cnt_r;
    logic [7:0] working_byte_r;
    logic carry_flag_r;
    logic zero_flag_r;
    logic neg_flag_r;
    logic done_r;
    logic dest_wr_r;
    logic [DATA_W-1:0] result_r;
    logic [BYTE_W-1:0] bytes_r;
    logic [STATE_W-1:0] states_r;
    logic [STATE_W-1:0] elapsed_r;

    logic accept_w;
    logic commit_w;
    logic unary_in_w;
    logic is_logic_w;
    logic acc_dest_w;
    logic word_w;
    logic reg_dest_w;
    logic [DATA_W-1:0] dst_sel_w;
    logic [DATA_W-1:0] src_sel_w;
    logic [DATA_W-1:0] logic_res_w;
    logic [DATA_W-1:0] res_w;
    logic [7:0] unary_w;
    logic [7:0] acc_nxt;
    logic carry_nxt;

    instr_timing u_timing (
        .tim(tim)
    );

    // Clear, complement and rotates always use the single-byte form
    assign unary_in_w = (op_i != bitwise_and_op) && (op_i != bitwise_or_op)
                     && (op_i != bitwise_xor_op);
    assign tim.form = unary_in_w ? form_acc_only : form_i;
    assign tim.native = native_mode_i;
    assign tim.loc = loc_i;
    assign tim.waits = wait_states_i;

    assign busy_o = (cnt_r != 6'h00);
    assign accept_w = start_i && !busy_o;
    assign commit_w = (cnt_r == 6'h01);

    assign is_logic_w = (op_r == bitwise_and_op) || (op_r == bitwise_or_op)
                     || (op_r == bitwise_xor_op);
    assign acc_dest_w = (form_r == form_acc_imm) || (form_r == form_acc_bank)
                     || (form_r == form_acc_short)
                     || (form_r == form_acc_ptr)
                     || (form_r == form_acc_only);
    assign word_w = (form_r == form_wreg_wreg) || (form_r == form_wreg_imm)
                 || (form_r == form_wreg_short)
                 || (form_r == form_wreg_long);
    assign reg_dest_w = !acc_dest_w && (form_r != form_short_acc)
                     && (form_r != form_short_imm);

    // Short direct destination with working byte source (form_short_acc) combines the working byte in as source
    assign dst_sel_w = acc_dest_w ? {8'h00, working_byte_r} : dst_r;
    assign src_sel_w = (form_r == form_short_acc) ? {8'h00, working_byte_r}
                                                  : src_r;

    assign logic_res_w = (op_r == bitwise_and_op) ? (dst_sel_w & src_sel_w) :
                         (op_r == bitwise_or_op) ? (dst_sel_w | src_sel_w) :
                         (dst_sel_w ^ src_sel_w);
    assign res_w = word_w ? logic_res_w : {8'h00, logic_res_w[7:0]};

    assign unary_w =
        (op_r == zero_working_byte) ? 8'h00 :
        (op_r == invert_working_byte) ? ~working_byte_r :
        (op_r == rotate_left_plain) ?
            {working_byte_r[6:0], working_byte_r[7]} :
        (op_r == rotate_left_with_carry) ?
            {working_byte_r[6:0], carry_flag_r} :
        (op_r == rotate_right_plain) ?
            {working_byte_r[0], working_byte_r[7:1]} :
            {carry_flag_r, working_byte_r[7:1]};

    assign acc_nxt = is_logic_w ? res_w[7:0] : unary_w;
    assign carry_nxt =
        (op_r == rotate_left_with_carry) ? working_byte_r[7] :
        (op_r == rotate_right_with_carry) ? working_byte_r[0] :
        carry_flag_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            op_r <= bitwise_and_op;
            form_r <= form_acc_only;
            dst_r <= 16'h0000;
            src_r <= 16'h0000;
            bytes_r <= 4'h0;
            states_r <= 6'h00;
        end else if (accept_w) begin
            op_r <= op_i;
            form_r <= tim.form;
            dst_r <= dest_data_i;
            src_r <= src_data_i;
            bytes_r <= tim.bytes;
            states_r <= tim.states;
        end
    end

    // One clock cycle per instruction state; commit on the last one
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= 6'h00;
        end else if (accept_w) begin
            cnt_r <= tim.states;
        end else if (busy_o) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            working_byte_r <= WORKING_BYTE_RST;
            carry_flag_r <= 1'b0;
        end else if (commit_w && acc_dest_w) begin
            working_byte_r <= acc_nxt;
            carry_flag_r <= carry_nxt;
        end
    end

    // Memory destinations are not flagged, matching the accumulator forms
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            zero_flag_r <= 1'b0;
            neg_flag_r <= 1'b0;
        end else if (commit_w && is_logic_w && reg_dest_w) begin
            zero_flag_r <= (res_w == 16'h0000);
            neg_flag_r <= word_w ? res_w[15] : res_w[7];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_r <= 1'b0;
            dest_wr_r <= 1'b0;
            result_r <= 16'h0000;
        end else begin
            done_r <= commit_w;
            dest_wr_r <= commit_w && !acc_dest_w;
            if (commit_w) begin
                result_r <= acc_dest_w ? {8'h00, acc_nxt} : res_w;
            end
        end
    end

    // Helper for checking that an instruction lasts exactly its states
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            elapsed_r <= 6'h00;
        end else if (accept_w) begin
            elapsed_r <= 6'h00;
        end else if (busy_o) begin
            elapsed_r <= elapsed_r + 6'h01;
        end
    end

    assign done_o = done_r;
    assign dest_wr_o = dest_wr_r;
    assign result_o = result_r;
    assign working_byte_o = working_byte_r;
    assign carry_flag_o = carry_flag_r;
    assign zero_flag_o = zero_flag_r;
    assign neg_flag_o = neg_flag_r;
    assign instr_bytes_o = bytes_r;
    assign instr_states_o = states_r;

    a_imm_acc_timing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_acc_imm
        |=> bytes_r == 4'h2 && states_r == 6'h01 ##1 done_o)
        else $error("immediate to working byte timing wrong");

    a_bank_mode_cost: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_acc_bank
        |-> tim.states == (native_mode_i ? 6'h02 : 6'h01)
            && tim.bytes == (native_mode_i ? 4'h2 : 4'h1))
        else $error("bank register form cost wrong");

    a_ptr_states: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_acc_ptr
        |-> tim.states == (native_mode_i ? 6'h03 : 6'h02))
        else $error("pointer indirect state count wrong");

    a_reg_pair_cost: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_reg_reg
        |-> tim.bytes == (native_mode_i ? 4'h2 : 4'h3)
            && tim.states == (native_mode_i ? 6'h01 : 6'h02))
        else $error("byte register pair cost wrong");

    a_port_read_add: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_acc_short && loc_i == loc_port
        |-> tim.states == 6'h02)
        else $error("port read penalty wrong");

    a_rmw_sfr_add: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_short_acc && loc_i == loc_sfr
        |-> tim.states == 6'h05 ##2 busy_o ##3 done_o && dest_wr_o)
        else $error("peripheral read-modify-write penalty wrong");

    a_ext_byte_add: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_reg_long && loc_i == loc_external
        && !native_mode_i
        |-> tim.states == {3'h0, wait_states_i} + 6'h05)
        else $error("external byte penalty wrong");

    a_ext_word_add: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        accept_w && tim.form == form_wreg_long && loc_i == loc_external
        && native_mode_i
        |-> tim.states == {2'h0, wait_states_i, 1'b0} + 6'h07)
        else $error("external word penalty wrong");

    a_done_after_states: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        commit_w |-> elapsed_r + 6'h01 == states_r ##1 done_o && !busy_o)
        else $error("instruction length in states wrong");

    a_rlc_through_carry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done_o && op_r == rotate_left_with_carry
        |-> carry_flag_o == $past(working_byte_o[7])
            && working_byte_o == {$past(working_byte_o[6:0]),
                                  $past(carry_flag_o)})
        else $error("rotate left through carry wrong");

    a_rrc_through_carry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done_o && op_r == rotate_right_with_carry
        |-> carry_flag_o == $past(working_byte_o[0])
            && working_byte_o == {$past(carry_flag_o),
                                  $past(working_byte_o[7:1])})
        else $error("rotate right through carry wrong");

    a_plain_keeps_carry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done_o && !is_logic_w && op_r != rotate_left_with_carry
        && op_r != rotate_right_with_carry
        |-> $stable(carry_flag_o) && instr_states_o == 6'h01)
        else $error("plain byte operation touched carry");

    a_reg_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done_o && is_logic_w && reg_dest_w
        |-> zero_flag_o == (result_o == 16'h0000) && $stable(carry_flag_o))
        else $error("register logical flags wrong");

endmodule

`default_nettype wire

// File: bench/logic_rotate_alu_test.sv
/*
 * Self-checking bench for the logical and rotate datapath: timing table,
 * location penalties, working byte results, rotates and register flags.
 * Assumes the design package and the datapath with its lookup compiled.
 */
`timescale 1ns/1ns
`default_nettype none

module logic_rotate_alu_test;
    import lrot_pkg::*;

    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic start_i = 1'b0;
    alu_op_t op_i = bitwise_and_op;
    form_t form_i = form_acc_imm;
    logic native_mode_i = 1'b0;
    loc_t loc_i = loc_internal;
    logic [WAIT_W-1:0] wait_states_i = 3'h0;
    logic [DATA_W-1:0] dest_data_i = 16'h0000;
    logic [DATA_W-1:0] src_data_i = 16'h0000;
    logic busy_o, done_o, dest_wr_o, carry_flag_o, zero_flag_o, neg_flag_o;
    logic [DATA_W-1:0] result_o;
    logic [7:0] working_byte_o;
    logic [BYTE_W-1:0] instr_bytes_o;
    logic [STATE_W-1:0] instr_states_o;
    int miscompares = 0;
    int comparisons = 0;
    int cyc;
    logic wr_seen;

    // Legacy bytes, legacy states, native bytes, native states per form
    localparam logic [15:0] TIM [17] = '{16'h2121, 16'h1122, 16'h2121,
        16'h1223, 16'h2222, 16'h3333, 16'h3221, 16'h3322, 16'h4332,
        16'h5443, 16'h4332, 16'h4433, 16'h5342, 16'h5443, 16'h4332,
        16'h4433, 16'h1111};
    localparam form_t PF [10] = '{form_acc_short, form_acc_short,
        form_reg_short, form_short_acc, form_short_imm, form_reg_long,
        form_reg_ind_dword, form_wreg_long, form_wreg_long, form_wreg_short};
    localparam loc_t PL [10] = '{loc_port, loc_sfr, loc_port, loc_port,
        loc_sfr, loc_external, loc_external, loc_external, loc_external,
        loc_port};
    localparam logic [2:0] PN [10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3,
        3'h0, 3'h2, 3'h7, 3'h0};
    localparam int PX [10] = '{1, 2, 1, 2, 3, 5, 2, 8, 18, 0};
    localparam alu_op_t RO [11] = '{rotate_left_with_carry,
        rotate_left_with_carry, rotate_right_with_carry, rotate_left_plain,
        rotate_right_plain, rotate_right_plain, rotate_right_plain,
        invert_working_byte, rotate_right_with_carry,
        rotate_left_with_carry, zero_working_byte};
    localparam logic [8:0] RE [11] = '{9'h102, 9'h005, 9'h102, 9'h104,
        9'h102, 9'h101, 9'h180, 9'h17F, 9'h1BF, 9'h17F, 9'h100};

    always #50 clk_i = ~clk_i;

    logic_rotate_alu i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
        .op_i(op_i), .form_i(form_i), .native_mode_i(native_mode_i),
        .loc_i(loc_i), .wait_states_i(wait_states_i),
        .dest_data_i(dest_data_i), .src_data_i(src_data_i),
        .busy_o(busy_o), .done_o(done_o), .dest_wr_o(dest_wr_o),
        .result_o(result_o), .working_byte_o(working_byte_o),
        .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o),
        .neg_flag_o(neg_flag_o), .instr_bytes_o(instr_bytes_o),
        .instr_states_o(instr_states_o)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    // One instruction; cyc counts edges from accept to the done cycle
    task automatic run(input alu_op_t op, input form_t f, input logic nat,
                       input loc_t l, input logic [2:0] n,
                       input logic [15:0] d, input logic [15:0] s);
        @(posedge clk_i);
        start_i <= 1'b1;
        op_i <= op;
        form_i <= f;
        native_mode_i <= nat;
        loc_i <= l;
        wait_states_i <= n;
        dest_data_i <= d;
        src_data_i <= s;
        @(posedge clk_i);
        start_i <= 1'b0;
        cyc = 0;
        while (cyc < 64) begin
            @(posedge clk_i);
            cyc++;
            #1;
            if (done_o === 1'b1) break;
        end
        wr_seen = dest_wr_o;
    endtask

    task automatic test_reset;
        @(posedge clk_i);
        #1;
        check({busy_o, done_o, dest_wr_o, carry_flag_o, zero_flag_o,
               neg_flag_o}, 16'h0000, "reset status");
        check({working_byte_o, 4'h0, instr_bytes_o}, 16'h0000, "reset wb");
        check(result_o, 16'h0000, "reset result");
        $display("test_reset finished");
    endtask

    task automatic test_timing;
        logic [3:0] eb, es;
        for (int m = 0; m < 2; m++) begin
            for (int f = 0; f < FORM_COUNT; f++) begin
                run(bitwise_or_op, form_t'(f), m[0], loc_internal, 3'h0,
                    16'h0000, 16'h0000);
                eb = m[0] ? TIM[f][7:4] : TIM[f][15:12];
                es = m[0] ? TIM[f][3:0] : TIM[f][11:8];
                check(16'(instr_bytes_o), 16'(eb), "bytes");
                check(16'(instr_states_o), 16'(es), "states");
                check(16'(cyc), 16'(es), "cycles");
            end
        end
        $display("test_timing finished");
    endtask

    task automatic test_penalty;
        int es;
        for (int i = 0; i < 10; i++) begin
            run(bitwise_and_op, PF[i], i[0], PL[i], PN[i], 16'h00FF,
                16'h00FF);
            es = (i[0] ? TIM[PF[i]][3:0] : TIM[PF[i]][11:8]) + PX[i];
            check(16'(instr_states_o), 16'(es), "penalty");
            check(16'(cyc), 16'(es), "penalty cycles");
        end
        $display("test_penalty finished");
    endtask

    task automatic test_acc;
        run(zero_working_byte, form_acc_only, 1'b0, loc_internal, 3'h0,
            16'h0000, 16'h0000);
        run(invert_working_byte, form_acc_only, 1'b1, loc_internal, 3'h0,
            16'h0000, 16'h0000);
        check(16'(working_byte_o), 16'h00FF, "complement");
        run(bitwise_and_op, form_acc_imm, 1'b0, loc_internal, 3'h0,
            16'h0000, 16'h005A);
        check(16'(working_byte_o), 16'h005A, "and");
        run(bitwise_or_op, form_acc_imm, 1'b1, loc_internal, 3'h0,
            16'h0000, 16'h0081);
        check(16'(working_byte_o), 16'h00DB, "or");
        run(bitwise_xor_op, form_acc_imm, 1'b0, loc_internal, 3'h0,
            16'h0000, 16'hFFFF);
        check({result_o[15:8], working_byte_o}, 16'h0024, "xor");
        check({15'h0000, wr_seen}, 16'h0000, "acc store");
        $display("test_acc finished");
    endtask

    // Unary ops get a costly form on purpose: their timing ignores it
    task automatic test_rotate;
        run(bitwise_xor_op, form_acc_imm, 1'b0, loc_internal, 3'h0,
            16'h0000, 16'h00A5);
        for (int i = 0; i < 11; i++) begin
            run(RO[i], form_wreg_long, i[0], loc_external, 3'h7, 16'h0000,
                16'h0000);
            check({7'h00, carry_flag_o, working_byte_o}, 16'(RE[i]), "rot");
            check(16'(cyc), 16'h0001, "rot cycles");
            check(16'(instr_bytes_o), 16'h0001, "rot bytes");
        end
        $display("test_rotate finished");
    endtask

    // Runs after the rotates, so carry is 1 and must stay so
    task automatic test_flags;
        run(bitwise_and_op, form_wreg_wreg, 1'b0, loc_internal, 3'h0,
            16'hF0F0, 16'h8F0F);
        check({result_o[15:3], wr_seen, zero_flag_o, neg_flag_o}, 16'h8005,
              "word and");
        run(bitwise_xor_op, form_wreg_wreg, 1'b1, loc_internal, 3'h0,
            16'h1234, 16'h1234);
        check({result_o[15:2], zero_flag_o, neg_flag_o}, 16'h0002,
              "word xor");
        run(bitwise_or_op, form_reg_reg, 1'b0, loc_internal, 3'h0,
            16'h0070, 16'hFF81);
        check(result_o, 16'h00F1, "byte or");
        check({zero_flag_o, neg_flag_o, carry_flag_o}, 16'h0003, "flg");
        run(bitwise_or_op, form_wreg_imm, 1'b1, loc_internal, 3'h0,
            16'h0000, 16'h0001);
        check({zero_flag_o, neg_flag_o}, 16'h0000, "imm flags");
        // Zero result into memory must not touch the register flags
        run(bitwise_and_op, form_short_imm, 1'b0, loc_internal, 3'h0,
            16'h00F0, 16'h000F);
        check({result_o[15:2], wr_seen, zero_flag_o}, 16'h0002, "mem");
        check(16'(carry_flag_o), 16'h0001, "carry kept");
        $display("test_flags finished");
    endtask

    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run needs 66 instructions of at most 24 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        test_reset();
        test_timing();
        test_penalty();
        test_acc();
        test_rotate();
        test_flags();
        conclude();
    end
endmodule

`default_nettype wire
